/* File: acs_pkg.sv */
// Package of constants and types for the conversion sequencer
// Behaviour
// RULE_01: Control bits 7 and 8 pick mode.
// RULE_02: Normal mode: trigger write starts conversion N.
// RULE_03: Pipeline on loads previous result N-1.
// RULE_04: Control write with bit7 clear selects normal.
// RULE_05: Settle busy flag high while settling runs.
// RULE_06: Host waits settle busy low before trigger.
// RULE_07: Busy flag high during conversion; host waits.
// RULE_08: New selection accepted during running conversion.
// RULE_09: Normal mode gives settle and convert interrupts.
// RULE_10: Automatic mode starts conversion after settling.
// RULE_11: Automatic busy spans all; one interrupt only.
// RULE_12: Normal, no pipeline: within 20 us.
// RULE_13: Normal pipeline: 10 us, 12.5 us on change; code keeps 10 us on change.
// RULE_14: Automatic, no pipeline: 30 us.
// RULE_15: Automatic with pipeline: 20 us.
// RULE_16: Same channel and gain: host skips settle poll.
// RULE_17: Host discards two dummy conversions after power-up; code passes them on, flagged by res_dummy.
// RULE_18: Trigger writes ignored while busy flag set.
// RULE_19: Settling interval about 10 us, any gain.
// RULE_20: Settle done interrupt on line 1, normal only.
// RULE_21: Data ready interrupt on line 0.
// RULE_22: Held last result resets to zero.
package acs_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_NS = 25;
  // Register offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_TRIGGER = 4'h7;
  // Control field positions
  localparam int unsigned BIT_AUTO = 7;
  localparam int unsigned BIT_PIPE = 8;
  localparam int unsigned BIT_INTENA = 9;
  localparam int unsigned BIT_DIFF = 4;
  localparam int unsigned BIT_GAIN_LO = 5;
  localparam int unsigned BIT_GAIN_HI = 6;
  localparam int unsigned BIT_CHAN_HI = 3;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_MSB = 6;
  // Status field positions
  localparam int unsigned BIT_SETTLE_BUSY = 0;
  localparam int unsigned BIT_ADC_BUSY = 1;
  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // Times in ns
  localparam int unsigned SETTLE_NS = 10000;
  localparam int unsigned T_NORM_NS = 20000;
  localparam int unsigned T_NPIPE_NS = 10000;
  localparam int unsigned T_NPIPE_CHG_NS = 12500;
  localparam int unsigned T_AUTO_NS = 30000;
  localparam int unsigned T_APIPE_NS = 20000;
  // Cycle counts; longest times round down
  localparam int unsigned SETTLE_CYC = SETTLE_NS / CLK_NS;
  localparam int unsigned CONV_NORM_CYC = T_NORM_NS / CLK_NS;
  localparam int unsigned CONV_NPIPE_CYC = T_NPIPE_NS / CLK_NS;
  localparam int unsigned CONV_AUTO_CYC = (T_AUTO_NS - SETTLE_NS) / CLK_NS;
  localparam int unsigned CONV_APIPE_CYC = (T_APIPE_NS - SETTLE_NS) / CLK_NS;
  localparam int unsigned CHG_EXTRA_NS = T_NPIPE_CHG_NS - T_NPIPE_NS;
  localparam int unsigned CNT_W = 11;
  localparam int unsigned DUMMY_CONVS = 2;
  // Host sequencer states
  typedef enum logic [2:0] {
    ACS_H_IDLE, ACS_H_CTRL, ACS_H_POLL, ACS_H_TRIG, ACS_H_WAIT, ACS_H_READ
  } acs_hstate_e;
endpackage

/* File: acs_bus_if.sv */
// Interface joining host and sequencer over the module register bus
`timescale 1ns/1ps
interface acs_bus_if;
  logic        wr;       // One-cycle write strobe
  logic        rd;       // One-cycle read strobe
  logic [3:0]  addr;     // Byte offset
  logic [15:0] wdata;    // Write data
  logic [15:0] rdata;    // Registered read data
  logic        rvalid;   // Read data valid pulse
  logic        irq0_n;   // Data ready request, active low
  logic        irq1_n;   // Settle done request, active low
  logic        iack;     // Acknowledge pulse from host
  modport dev  (input wr, rd, addr, wdata, iack, output rdata, rvalid, irq0_n, irq1_n);
  modport host (output wr, rd, addr, wdata, iack, input rdata, rvalid, irq0_n, irq1_n);
endinterface

/* File: acs_timer.sv */
// Down counter that pulses once when a loaded count runs out
`timescale 1ns/1ps
module acs_timer
  import acs_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  // Elaboration check: a one-bit counter cannot time anything useful
  if (W < 2) begin : g_w_check
    $error("acs_timer: width too small");
  end
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } acs_tmr_s;
  acs_tmr_s r;       // Registered state
  acs_tmr_s next_r;  // Next state
  // Load wins over countdown so a reload restarts timing
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (load) begin
      next_r.cnt = count;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
      if (r.cnt == W'(1)) begin
        next_r.done = 1'b1;
      end
    end
  end
  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign busy = (r.cnt != '0);
  assign done = r.done;
endmodule

/* File: acs_device.sv */
// Conversion sequencer: control, status, result registers and timing
`timescale 1ns/1ps
module acs_device
  import acs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  acs_bus_if.dev           bus,
  input  wire logic [11:0] adc_sample,   // Converter output for the selected input
  output logic [6:0]       adc_select    // Channel, diff and gain applied to the mux
);
  // Sequencing in brief:
  //  - a control write loads the selection and restarts the settling timer
  //  - normal mode converts on a trigger write; settling and conversion may overlap
  //  - automatic mode chains settling and conversion under one busy flag
  //  - with the pipeline on, the previous result moves out as a new one starts
  //  - the host must honour the busy flags; only trigger writes are refused here
  // Hazards and limits:
  //  - a channel change under the pipeline is not timed longer; the conversion
  //    simply runs its fixed length after the settling
  //  - a control write during a conversion must not disturb that conversion,
  //    so the two timers are kept separate
  //  - a normal write while an automatic start is pending cancels the start, unless settling ends in that same cycle
  //  - interrupt requests stay set until acknowledged; a new event in the
  //    acknowledge cycle wins
  // All sequencer state in one word; reset clears every field to zero
  typedef struct packed {
    logic [15:0] control;   // Control register
    logic [15:0] result;    // Sample result register
    logic [15:0] held;      // Last completed result
    logic        conv_busy; // Conversion running
    logic        auto_wait; // Automatic: waiting for settling
    logic        irq0;      // Data ready pending
    logic        irq1;      // Settle done pending
    logic [15:0] rdata;
    logic        rvalid;
    logic [6:0]  sel;
  } acs_dev_s;
  acs_dev_s r;       // Registered state
  acs_dev_s next_r;  // Next state

  // Every count must fit the shared timer width, or a conversion ends early
  if (SETTLE_CYC >= (1 << CNT_W) || CONV_NORM_CYC >= (1 << CNT_W)
      || CONV_AUTO_CYC >= (1 << CNT_W) || CONV_APIPE_CYC >= (1 << CNT_W)) begin : g_cnt_check
    $error("acs_device: cycle counts exceed the timer width");
  end

  // Timer handshakes
  logic                     settle_load;   // Restart settling
  logic                     settle_busy;   // Settling in progress
  logic                     settle_done;   // Settling ended this cycle
  logic                     conv_load;     // Start a conversion
  logic [CNT_W-1:0]         conv_count;    // Length of that conversion
  logic                     conv_done;     // Conversion ended this cycle
  logic                     conv_running;  // Conversion timer still counting
  // Bus decode and mode
  logic                     wr_ctrl;       // Host writes the control word
  logic                     wr_trig;       // Host writes the trigger
  logic                     wr_result;     // Host writes the result word
  logic                     auto_mode;     // Automatic settling selected
  logic                     pipe_mode;     // Result pipeline selected
  // Data paths
  logic [15:0]              sample_word;   // Converter value in result format
  logic [15:0]              status_word;   // Status as the host reads it

  // Settling timer; every control write restarts it, in both modes
  acs_timer #(.W(CNT_W)) u_settle (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .load    (settle_load),
    .count   (CNT_W'(SETTLE_CYC)),      // RULE_19
    .busy    (settle_busy),             // RULE_05
    .done    (settle_done)
  );
  // Conversion timer; its busy output guards a switch out of automatic mode
  acs_timer #(.W(CNT_W)) u_conv (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .load    (conv_load),
    .count   (conv_count),
    .busy    (conv_running),
    .done    (conv_done)
  );

  // Decode of bus writes
  assign wr_ctrl = bus.wr && (bus.addr == OFS_CONTROL);
  assign wr_trig = bus.wr && (bus.addr == OFS_TRIGGER);
  assign auto_mode = r.control[BIT_AUTO];   // RULE_01
  assign pipe_mode = r.control[BIT_PIPE];   // RULE_01
  assign settle_load = wr_ctrl;
  assign wr_result = bus.wr && (bus.addr == OFS_RESULT);
  // 12-bit sample left aligned in the result word
  assign sample_word = {adc_sample, 4'h0};

  // Status: bit 0 settling, bit 1 conversion; the rest reads zero
  always_comb begin
    status_word = 16'h0000;
    status_word[BIT_SETTLE_BUSY] = settle_busy;            // RULE_05
    status_word[BIT_ADC_BUSY] = r.conv_busy;               // RULE_07 RULE_11
  end

  // Conversion start and length per mode
  always_comb begin
    conv_load = 1'b0;
    conv_count = CNT_W'(CONV_NORM_CYC);                    // RULE_12
    // Normal: the host trigger starts it; a busy converter refuses the write
    if (!auto_mode) begin
      conv_load = wr_trig && !r.conv_busy;                 // RULE_02 RULE_18
      if (pipe_mode) begin
        conv_count = CNT_W'(CONV_NPIPE_CYC);               // RULE_13
      end
    end else begin
      // Automatic: the end of settling starts it; trigger writes do nothing
      conv_load = r.auto_wait && settle_done;              // RULE_10
      if (pipe_mode) begin
        conv_count = CNT_W'(CONV_APIPE_CYC);               // RULE_15
      end else begin
        conv_count = CNT_W'(CONV_AUTO_CYC);                // RULE_14
      end
    end
  end

  // Register and sequencing update
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    // Control write may land during a conversion; settling overlaps it
    if (wr_ctrl) begin
      next_r.control = bus.wdata;                          // RULE_04 RULE_08
      next_r.sel = bus.wdata[SEL_MSB:SEL_LSB];
      if (bus.wdata[BIT_AUTO]) begin
        next_r.auto_wait = 1'b1;                           // RULE_11
        next_r.conv_busy = 1'b1;                           // RULE_11
      end else if (r.auto_wait) begin
        // A normal write cancels a pending automatic start, unless settling ends in the same cycle
        next_r.auto_wait = 1'b0;
        next_r.conv_busy = conv_running;
      end
    end

    // Start of conversion N
    if (conv_load) begin
      next_r.auto_wait = 1'b0;
      next_r.conv_busy = 1'b1;                             // RULE_07
      // Pipeline shifts previous result in while N runs
      if (pipe_mode) begin
        next_r.result = r.held;                            // RULE_03
      end
    end

    // End of conversion: flag drops unless an automatic restart waits
    if (conv_done) begin
      next_r.conv_busy = next_r.auto_wait;                 // RULE_07
      next_r.held = sample_word;                           // RULE_22
      if (!pipe_mode) begin
        next_r.result = sample_word;                       // RULE_02
      end
    end
    // Interrupt acknowledge clears both; events below win
    if (bus.iack) begin
      next_r.irq0 = 1'b0;
      next_r.irq1 = 1'b0;
    end

    // Data ready on the falling edge of the busy flag
    if (conv_done && r.control[BIT_INTENA]) begin
      next_r.irq0 = 1'b1;                                  // RULE_21 RULE_09
    end
    // Settle falling edge only in normal mode
    if (settle_done && !auto_mode && r.control[BIT_INTENA]) begin
      next_r.irq1 = 1'b1;                                  // RULE_20 RULE_09
    end
    // Read data, answered one cycle after the strobe
    if (bus.rd) begin
      next_r.rvalid = 1'b1;
      case (bus.addr)
        OFS_CONTROL: next_r.rdata = r.control;
        OFS_RESULT:  next_r.rdata = r.result;
        OFS_STATUS:  next_r.rdata = status_word;           // RULE_05
        default:     next_r.rdata = 16'h0000;  // Unmapped reads zero
      endcase
    end
    // Host may overwrite the result word; its write beats a hardware load
    if (wr_result) begin
      next_r.result = bus.wdata;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from state flops; requests are active low
  assign bus.rdata = r.rdata;
  assign bus.rvalid = r.rvalid;
  assign bus.irq0_n = ~r.irq0;
  assign bus.irq1_n = ~r.irq1;
  assign adc_select = r.sel;
endmodule

/* File: acs_host.sv */
// Host end: writes control, waits, triggers, reads result
`timescale 1ns/1ps
module acs_host
  import acs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  acs_bus_if.host          bus,
  input  wire logic        cmd_valid,   // Request a conversion
  input  wire logic [15:0] cmd_control, // Control word to use
  output logic             cmd_ready,   // Idle, able to take a request
  output logic [15:0]      res_data,    // Result word
  output logic             res_valid,   // One-cycle result pulse
  output logic             res_dummy    // Result is a power-up dummy
);
  typedef struct packed {
    acs_hstate_e st;
    logic [15:0] ctrl;
    logic [15:0] last;   // Last control written
    logic        have;   // Control written before
    logic [1:0]  dummies;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        pend;   // Read in flight
    logic [15:0] data;
    logic        valid;
    logic        dummy;
  } acs_host_s;
  acs_host_s r;
  acs_host_s next_r;

  // Sequencer
  always_comb begin
    next_r = r;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    next_r.valid = 1'b0;
    case (r.st)
      ACS_H_IDLE: if (cmd_valid) begin
        next_r.ctrl = cmd_control;
        // Skip the control write when the control word is unchanged and not automatic
        if (r.have && cmd_control == r.last && !cmd_control[BIT_AUTO]) begin
          next_r.st = ACS_H_TRIG;                          // RULE_16
        end else begin
          next_r.st = ACS_H_CTRL;
        end
      end
      ACS_H_CTRL: begin
        next_r.wr = 1'b1;
        next_r.addr = OFS_CONTROL;
        next_r.wdata = r.ctrl;
        next_r.last = r.ctrl;
        next_r.have = 1'b1;
        next_r.st = r.ctrl[BIT_AUTO] ? ACS_H_WAIT : ACS_H_POLL;
      end
      ACS_H_POLL, ACS_H_WAIT: begin
        // Poll status until the relevant busy bit is low
        if (!r.pend) begin
          next_r.rd = 1'b1;
          next_r.addr = OFS_STATUS;
          next_r.pend = 1'b1;
        end else if (bus.rvalid) begin
          next_r.pend = 1'b0;
          if (r.st == ACS_H_POLL && !bus.rdata[BIT_SETTLE_BUSY]) begin
            next_r.st = ACS_H_TRIG;                        // RULE_06
          end else if (r.st == ACS_H_WAIT && !bus.rdata[BIT_ADC_BUSY]) begin
            next_r.st = ACS_H_READ;                        // RULE_07
          end
        end
      end
      ACS_H_TRIG: begin
        next_r.wr = 1'b1;
        next_r.addr = OFS_TRIGGER;
        next_r.wdata = 16'h0000;
        next_r.st = ACS_H_WAIT;
      end
      ACS_H_READ: begin
        if (!r.pend) begin
          next_r.rd = 1'b1;
          next_r.addr = OFS_RESULT;
          next_r.pend = 1'b1;
        end else if (bus.rvalid) begin
          next_r.pend = 1'b0;
          next_r.data = bus.rdata;
          next_r.valid = 1'b1;
          next_r.dummy = (r.dummies < 2'(DUMMY_CONVS));    // RULE_17
          if (r.dummies < 2'(DUMMY_CONVS)) begin
            next_r.dummies = r.dummies + 2'd1;
          end
          next_r.st = ACS_H_IDLE;
        end
      end
      default: next_r.st = ACS_H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bus.wr = r.wr;
  assign bus.rd = r.rd;
  assign bus.addr = r.addr;
  assign bus.wdata = r.wdata;
  assign bus.iack = 1'b0;   // Host polls; no acknowledge cycles
  assign cmd_ready = (r.st == ACS_H_IDLE);
  assign res_data = r.data;
  assign res_valid = r.valid;
  assign res_dummy = r.dummy;
endmodule

/* File: acs_props.sv */
// Concurrent checks on the bus between host and conversion sequencer
`timescale 1ns/1ps
module acs_props
  import acs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        irq0_n,
  input  wire logic        irq1_n,
  input  wire logic        iack
);
  logic [15:0] ctl;    // Last control word written
  int unsigned scnt;   // Cycles since control write
  int unsigned tcnt;   // Cycles since accepted trigger
  logic        rd_st;  // Status read answered this cycle
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Bus history; counters saturate so they never wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl   <= 16'h0000;
      scnt  <= 5000;
      tcnt  <= 5000;
      rd_st <= 1'b0;
    end else begin
      rd_st <= rd && addr == OFS_STATUS;
      // Control write restarts settling
      if (wr && addr == OFS_CONTROL) begin
        ctl  <= wdata;
        scnt <= 0;
      end else if (scnt < 5000) begin
        scnt <= scnt + 1;
      end
      // Trigger counted only when no conversion can still run
      if (wr && addr == OFS_TRIGGER && !ctl[7] && tcnt > (ctl[8] ? 400 : 800)) begin
        tcnt <= 0;
      end else if (tcnt < 5000) begin
        tcnt <= tcnt + 1;
      end
    end
  end
  // Margins of ten cycles, five for the settle request, absorb register stages on the bus
  property p_settle_on; rvalid && rd_st && !ctl[7] && scnt < 390 |-> rdata[0]; endproperty
  a_settle_on: assert property (p_settle_on) else $error("settle flag low too early");
  property p_settle_off; rvalid && rd_st && !ctl[7] && scnt > 410 |-> !rdata[0]; endproperty
  a_settle_off: assert property (p_settle_off) else $error("settle flag too long");
  property p_auto_nopipe;
    rvalid && rd_st && ctl[7] && !ctl[8] |-> (scnt > 1190 || rdata[1]) && (scnt < 1210 || !rdata[1]);
  endproperty
  a_auto_nopipe: assert property (p_auto_nopipe) else $error("auto busy span wrong");
  property p_auto_pipe;
    rvalid && rd_st && ctl[7] && ctl[8] |-> (scnt > 790 || rdata[1]) && (scnt < 810 || !rdata[1]);
  endproperty
  a_auto_pipe: assert property (p_auto_pipe) else $error("auto pipe busy span wrong");
  property p_norm_conv;
    rvalid && rd_st && !ctl[7] |-> (tcnt > (ctl[8] ? 390 : 790) || rdata[1])
      && (tcnt < (ctl[8] ? 410 : 810) || !rdata[1]);
  endproperty
  a_norm_conv: assert property (p_norm_conv) else $error("normal busy span wrong");
  property p_irq_settle; $fell(irq1_n) |-> !ctl[7] && ctl[9] && scnt inside {[395:405]}; endproperty
  a_irq_settle: assert property (p_irq_settle) else $error("settle request misplaced");
  property p_irq_data; $fell(irq0_n) |-> ctl[9]; endproperty
  a_irq_data: assert property (p_irq_data) else $error("data request while disabled");
  property p_irq_hold; !irq0_n && !iack |=> !irq0_n; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("data request dropped");
  property p_rd_ans; rd |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
endmodule

/* File: tb_top.sv */
// Testbench joining host and sequencer, with a result model
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import acs_pkg::*;
  logic        sys_clk = 1'b0;  // 40 MHz system clock
  logic        resetn;          // Active low reset
  logic        cmd_valid;       // Conversion request
  logic [15:0] cmd_control;     // Control word for request
  logic [11:0] adc_sample;      // Converter value, held per request
  logic        cmd_ready;
  logic [15:0] res_data;
  logic        res_valid;
  logic        res_dummy;
  logic [6:0]  adc_select;
  logic [15:0] held;            // Model of the held previous result
  int          nres;            // Results since reset
  int          err_total;
  int          num_checks;
  acs_bus_if bus ();
  acs_device i_acs_device (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
    .adc_sample(adc_sample), .adc_select(adc_select));
  acs_host i_acs_host (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_control(cmd_control), .cmd_ready(cmd_ready),
    .res_data(res_data), .res_valid(res_valid), .res_dummy(res_dummy));
  acs_props i_acs_props (.sys_clk(sys_clk), .resetn(resetn), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
    .irq0_n(bus.irq0_n), .irq1_n(bus.irq1_n), .iack(bus.iack));
  // Half period of 12.5 ns
  always #12.5 sys_clk = ~sys_clk;
  // Verdict in one place
  task test_done;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset for three cycles; model forgets held value too
  task do_reset;
    @(negedge sys_clk) resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    held = 16'h0000;
    nres = 0;
    resetn = 1'b1;
  endtask
  // One request through the host; checks result against the model
  task run(input logic [15:0] c);
    int          n;
    logic [15:0] e;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (cmd_ready === 1'b1) begin
      @(negedge sys_clk);
      adc_sample  = 12'($urandom);
      cmd_control = c;
      cmd_valid   = 1'b1;
      @(negedge sys_clk) cmd_valid = 1'b0;
      n = 0;
      // Bounded wait for the result pulse
      while (res_valid !== 1'b1 && n < 4000) begin
        @(negedge sys_clk);
        n++;
      end
    end else begin
      n = 4000;
    end
    // Either wait running out counts once and ends the run
    if (n >= 4000) begin
      err_total++;
      test_done();
    end else begin
      e = c[8] ? held : {adc_sample, 4'h0};
      held = {adc_sample, 4'h0};
      `CHK(res_data, e)
      `CHK(res_dummy, (nres < 2))
      `CHK(adc_select, c[6:0])
      nres++;
      $display("test ctl=%h result=%h done", c, res_data);
    end
  endtask
  // Main sequence
  initial begin
    resetn      = 1'b0;
    cmd_valid   = 1'b0;
    cmd_control = 16'h0000;
    adc_sample  = 12'h000;
    held        = 16'h0000;
    void'($urandom(36940));
    do_reset();
    run(16'h0285);
    `CHK(bus.irq0_n, 1'b0)
    `CHK(bus.irq1_n, 1'b1)
    run(16'h0213);
    `CHK(bus.irq1_n, 1'b0)
    // Every mode three times, random selection and enable
    for (int i = 0; i < 12; i++) begin
      run({6'h00, 1'($urandom), 2'(i), 7'($urandom)});
    end
    // Second reset: pipelined first result must be zero
    do_reset();
    run(16'h0100);
    // Same selection again: host skips the control write and settle poll
    run(16'h0100);
    `CHK(bus.irq0_n, 1'b1)
    test_done();
  end
endmodule
